/* File: hw/pcr_config_regs.sv */
/*
  I2C target register bank of a one-PLL clock generator: bus engine,
  register pointer, volatile configuration registers and read-back.
  Assumes SCL and SDA arrive synchronous to MCLK and many MCLK cycles per
  SCL phase; the open-drain SDA wire is resolved outside.
*/
`default_nettype none

module pcr_config_regs (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic SERIAL_DATA_PIN_IN,
  output logic SERIAL_DATA_PIN_OUT,
  output logic SERIAL_DATA_PIN_OE_N,
  output pcr_pkg::pcr_cfg_t CFG
);
  import pcr_pkg::*;

  logic scl_q, sda_q, scl_prev, sda_prev;
  logic scl_rise, scl_fall, start_det, stop_det;
  pcr_state_t state_reg;
  logic [3:0] bitcnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic commit_reg;
  logic [7:0] commit_addr_reg;
  logic [7:0] commit_data_reg;
  logic [7:0] rd_byte;
  pcr_cfg_t cfg_reg;
  pcr_oe_byte_t commit_oe;
  pcr_osc_byte_t commit_osc;
  pcr_pump_byte_t commit_pump;
  pcr_sel_div_byte_t commit_sel;
  pcr_xpt_c_byte_t commit_xpt;
  pcr_pump_byte_t rd_pump;

  // ==========================================================================
  // Pin sampling and bus conditions
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_q <= SERIAL_CLOCK_PIN;
      sda_q <= SERIAL_DATA_PIN_IN;
      scl_prev <= scl_q;
      sda_prev <= sda_q;
    end
  end

  // Edges of the sampled pins
  assign scl_rise = scl_q & ~scl_prev;
  assign scl_fall = ~scl_q & scl_prev;
  assign start_det = scl_q & scl_prev & sda_prev & ~sda_q;
  assign stop_det = scl_q & scl_prev & ~sda_prev & sda_q;

  // Field views of the committed byte and of the read-back byte
  assign commit_oe = commit_data_reg;
  assign commit_osc = commit_data_reg;
  assign commit_pump = commit_data_reg;
  assign commit_sel = commit_data_reg;
  assign commit_xpt = commit_data_reg;
  assign rd_pump = rd_byte;

  // ==========================================================================
  // Read-back of the addressed register, fixed bits included
  always_comb begin
    rd_byte = PCR_UNMAPPED_READ;
    case (ptr_reg)
      PCR_OFS_OUTPUT_ENABLE_CTRL: rd_byte = {PCR_OE_FIXED_HI, cfg_reg.output_enable_bits};
      PCR_OFS_BANK1_SOURCE_DIVIDER: rd_byte = {cfg_reg.bank1_source_select, cfg_reg.bank1_divide_value};
      PCR_OFS_OSC_DRIVE_CTRL: rd_byte = {PCR_OSC_FIXED_HI, cfg_reg.osc_gain_code, PCR_OSC_FIXED_LO};
      PCR_OFS_LOAD_CAP_CTRL: rd_byte = cfg_reg.load_cap_code;
      PCR_OFS_PUMP_FEEDBACK_HIGH: rd_byte = {PCR_PUMP_FIXED_HI, cfg_reg.pump_code,
                                             cfg_reg.feedback_base_count[9:8]};
      PCR_OFS_FEEDBACK_LOW: rd_byte = cfg_reg.feedback_base_count[7:0];
      PCR_OFS_ODD_BIT_REF_DIVIDER: rd_byte = {cfg_reg.feedback_odd_bit, cfg_reg.ref_divider};
      PCR_OFS_CROSSPOINT_SELECT_A: rd_byte = cfg_reg.output_source_select[17:10];
      PCR_OFS_CROSSPOINT_SELECT_B: rd_byte = cfg_reg.output_source_select[9:2];
      PCR_OFS_CROSSPOINT_SELECT_C: rd_byte = {cfg_reg.output_source_select[1:0], PCR_XPT_C_FIXED_LO};
      PCR_OFS_BANK2_SOURCE_DIVIDER: rd_byte = {cfg_reg.bank2_source_select, cfg_reg.bank2_divide_value};
      default: rd_byte = PCR_UNMAPPED_READ;
    endcase
  end

  // ==========================================================================
  // Bus engine: address, pointer, data, acknowledge and SDA drive
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      SERIAL_DATA_PIN_OE_N <= 1'b1;
      commit_reg <= 1'b0;
      commit_addr_reg <= 8'h00;
      commit_data_reg <= 8'h00;
    end else begin
      commit_reg <= 1'b0;
      if (start_det) begin
        state_reg <= ST_ADDR;
        bitcnt_reg <= 4'h0;
        SERIAL_DATA_PIN_OE_N <= 1'b1;
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        SERIAL_DATA_PIN_OE_N <= 1'b1;
      end else begin
        case (state_reg)
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_q};
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end else if (scl_fall && bitcnt_reg == PCR_BITS_PER_BYTE) begin
              bitcnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == PCR_DEV_ADDR) begin
                  rw_reg <= shift_reg[0];
                  SERIAL_DATA_PIN_OE_N <= 1'b0;
                  state_reg <= ST_ADDR_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else if (state_reg == ST_REG) begin
                ptr_reg <= shift_reg;
                SERIAL_DATA_PIN_OE_N <= 1'b0;
                state_reg <= ST_REG_ACK;
              end else begin
                SERIAL_DATA_PIN_OE_N <= 1'b0;
                state_reg <= ST_WDATA_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                shift_reg <= rd_byte;
                SERIAL_DATA_PIN_OE_N <= rd_byte[7];
                bitcnt_reg <= 4'h1;
                state_reg <= ST_RDATA;
              end else begin
                SERIAL_DATA_PIN_OE_N <= 1'b1;
                state_reg <= ST_REG;
              end
            end
          end
          ST_REG_ACK: begin
            if (scl_fall) begin
              SERIAL_DATA_PIN_OE_N <= 1'b1;
              state_reg <= ST_WDATA;
            end
          end
          ST_WDATA_ACK: begin
            if (scl_fall) begin
              // Byte is in and acknowledged: hand it to the register file
              SERIAL_DATA_PIN_OE_N <= 1'b1;
              commit_reg <= 1'b1;
              commit_addr_reg <= ptr_reg;
              commit_data_reg <= shift_reg;
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bitcnt_reg == PCR_BITS_PER_BYTE) begin
                SERIAL_DATA_PIN_OE_N <= 1'b1;
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_RDATA_ACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                SERIAL_DATA_PIN_OE_N <= shift_reg[6];
                bitcnt_reg <= bitcnt_reg + 4'h1;
              end
            end
          end
          ST_RDATA_ACK: begin
            if (scl_rise && sda_q) begin
              state_reg <= ST_IDLE; // Host refused more data
            end else if (scl_fall) begin
              shift_reg <= rd_byte;
              SERIAL_DATA_PIN_OE_N <= rd_byte[7];
              bitcnt_reg <= 4'h1;
              state_reg <= ST_RDATA;
            end
          end
          default: begin
            SERIAL_DATA_PIN_OE_N <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Volatile configuration registers, blank after every reset
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      cfg_reg <= PCR_CFG_POWERUP;
    end else if (commit_reg) begin
      case (commit_addr_reg)
        PCR_OFS_OUTPUT_ENABLE_CTRL:
          cfg_reg.output_enable_bits <= commit_oe.output_enable_bits;
        PCR_OFS_BANK1_SOURCE_DIVIDER: begin
          cfg_reg.bank1_source_select <= commit_sel.source_select;
          cfg_reg.bank1_divide_value <= commit_sel.value;
        end
        PCR_OFS_OSC_DRIVE_CTRL:
          cfg_reg.osc_gain_code <= commit_osc.osc_gain_code;
        PCR_OFS_LOAD_CAP_CTRL:
          cfg_reg.load_cap_code <= commit_data_reg;
        PCR_OFS_PUMP_FEEDBACK_HIGH: begin
          cfg_reg.pump_code <= commit_pump.pump_code;
          cfg_reg.feedback_base_count[9:8] <= commit_pump.feedback_high;
        end
        PCR_OFS_FEEDBACK_LOW:
          cfg_reg.feedback_base_count[7:0] <= commit_data_reg;
        PCR_OFS_ODD_BIT_REF_DIVIDER: begin
          cfg_reg.feedback_odd_bit <= commit_sel.source_select;
          cfg_reg.ref_divider <= commit_sel.value;
        end
        PCR_OFS_CROSSPOINT_SELECT_A:
          cfg_reg.output_source_select[17:10] <= commit_data_reg;
        PCR_OFS_CROSSPOINT_SELECT_B:
          cfg_reg.output_source_select[9:2] <= commit_data_reg;
        PCR_OFS_CROSSPOINT_SELECT_C:
          cfg_reg.output_source_select[1:0] <= commit_xpt.xpt_tail;
        PCR_OFS_BANK2_SOURCE_DIVIDER: begin
          cfg_reg.bank2_source_select <= commit_sel.source_select;
          cfg_reg.bank2_divide_value <= commit_sel.value;
        end
        default: begin
          cfg_reg <= cfg_reg; // Reserved and unmapped writes are dropped
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign CFG = cfg_reg;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      SERIAL_DATA_PIN_OUT <= 1'b0;
    end else begin
      SERIAL_DATA_PIN_OUT <= 1'b0; // Open drain only ever pulls low
    end
  end

  // ==========================================================================
  // Checks
  foreign_addr_a: assert property (@(posedge MCLK) disable iff (RESET)
    (state_reg == ST_ADDR && scl_fall && !start_det && !stop_det && bitcnt_reg == PCR_BITS_PER_BYTE
     && shift_reg[7:1] != PCR_DEV_ADDR) |=> (state_reg == ST_IDLE && SERIAL_DATA_PIN_OE_N))
    else $error("foreign address was answered");

  commit_after_ack_a: assert property (@(posedge MCLK) disable iff (RESET)
    commit_reg |-> ($past(state_reg) == ST_WDATA_ACK && !$past(SERIAL_DATA_PIN_OE_N)))
    else $error("write landed without acknowledge");

  powerup_blank_a: assert property (@(posedge MCLK)
    $fell(RESET) |-> (CFG == PCR_CFG_POWERUP))
    else $error("configuration not blank after reset");

  gain_field_a: assert property (@(posedge MCLK) disable iff (RESET)
    (commit_reg && commit_addr_reg == PCR_OFS_OSC_DRIVE_CTRL) |=>
      (CFG.osc_gain_code == $past(commit_osc.osc_gain_code)))
    else $error("oscillator gain not taken from bits 4..3");

  load_cap_a: assert property (@(posedge MCLK) disable iff (RESET)
    (commit_reg && commit_addr_reg == PCR_OFS_LOAD_CAP_CTRL) |=> (CFG.load_cap_code == $past(commit_data_reg)))
    else $error("load capacitance code not stored");

  enable_bits_a: assert property (@(posedge MCLK) disable iff (RESET)
    (commit_reg && commit_addr_reg == PCR_OFS_OUTPUT_ENABLE_CTRL) |=>
      (CFG.output_enable_bits == $past(commit_oe.output_enable_bits) && $stable(CFG.load_cap_code)))
    else $error("output enable bits not stored");

  bank_divider_a: assert property (@(posedge MCLK) disable iff (RESET)
    (commit_reg && commit_addr_reg == PCR_OFS_BANK2_SOURCE_DIVIDER) |=>
      ({CFG.bank2_source_select, CFG.bank2_divide_value} == $past(commit_data_reg)))
    else $error("bank two divider not stored");

  pump_fixed_a: assert property (@(posedge MCLK) disable iff (RESET)
    (ptr_reg == PCR_OFS_PUMP_FEEDBACK_HIGH) |-> (rd_pump.fixed_hi == PCR_PUMP_FIXED_HI))
    else $error("pump register fixed bits wrong");

  crosspoint_tail_a: assert property (@(posedge MCLK) disable iff (RESET)
    (commit_reg && commit_addr_reg == PCR_OFS_CROSSPOINT_SELECT_C) |=>
      (CFG.output_source_select[1:0] == $past(commit_xpt.xpt_tail))
      && $stable(CFG.output_source_select[17:2]))
    else $error("crosspoint tail not stored");

endmodule

`default_nettype wire

/* File: include/pcr_pkg.sv */
/*
  Shared constants and types of the PLL clock configuration register bank:
  register offsets, target bus address, fixed bit patterns, byte layouts
  and the packed configuration handed to the clock generator core.
  Assumes an I2C host with 8-bit register addresses and 8-bit data.
*/
`default_nettype none

package pcr_pkg;

  // ==========================================================================
  // Bus and register map
  localparam logic [6:0] PCR_DEV_ADDR = 7'h69;
  localparam logic [7:0] PCR_OFS_OUTPUT_ENABLE_CTRL = 8'h09;
  localparam logic [7:0] PCR_OFS_BANK1_SOURCE_DIVIDER = 8'h0c;
  localparam logic [7:0] PCR_OFS_OSC_DRIVE_CTRL = 8'h12;
  localparam logic [7:0] PCR_OFS_LOAD_CAP_CTRL = 8'h13;
  localparam logic [7:0] PCR_OFS_PUMP_FEEDBACK_HIGH = 8'h40;
  localparam logic [7:0] PCR_OFS_FEEDBACK_LOW = 8'h41;
  localparam logic [7:0] PCR_OFS_ODD_BIT_REF_DIVIDER = 8'h42;
  localparam logic [7:0] PCR_OFS_CROSSPOINT_SELECT_A = 8'h44;
  localparam logic [7:0] PCR_OFS_CROSSPOINT_SELECT_B = 8'h45;
  localparam logic [7:0] PCR_OFS_CROSSPOINT_SELECT_C = 8'h46;
  localparam logic [7:0] PCR_OFS_BANK2_SOURCE_DIVIDER = 8'h47;
  localparam logic [7:0] PCR_UNMAPPED_READ = 8'h00;

  // ==========================================================================
  // Fixed bit patterns and the bit count of a byte
  localparam logic [1:0] PCR_OE_FIXED_HI = 2'h0;
  localparam logic [2:0] PCR_OSC_FIXED_HI = 3'h1;
  localparam logic [2:0] PCR_OSC_FIXED_LO = 3'h0;
  localparam logic [2:0] PCR_PUMP_FIXED_HI = 3'h6;
  localparam logic [5:0] PCR_XPT_C_FIXED_LO = 6'h3f;
  localparam logic [3:0] PCR_BITS_PER_BYTE = 4'h8;

  // ==========================================================================
  // Byte layouts of the registers with several fields
  typedef struct packed {
    logic [1:0] fixed_hi;
    logic [5:0] output_enable_bits;
  } pcr_oe_byte_t;

  typedef struct packed {
    logic [2:0] fixed_hi;
    logic [1:0] osc_gain_code;
    logic [2:0] fixed_lo;
  } pcr_osc_byte_t;

  typedef struct packed {
    logic [2:0] fixed_hi;
    logic [2:0] pump_code;
    logic [1:0] feedback_high;
  } pcr_pump_byte_t;

  typedef struct packed {
    logic source_select;
    logic [6:0] value;
  } pcr_sel_div_byte_t;

  typedef struct packed {
    logic [1:0] xpt_tail;
    logic [5:0] fixed_lo;
  } pcr_xpt_c_byte_t;

  // Configuration driven into the clock core
  typedef struct packed {
    logic [5:0] output_enable_bits;
    logic bank1_source_select;
    logic [6:0] bank1_divide_value;
    logic [1:0] osc_gain_code;
    logic [7:0] load_cap_code;
    logic [2:0] pump_code;
    logic [9:0] feedback_base_count;
    logic feedback_odd_bit;
    logic [6:0] ref_divider;
    logic [17:0] output_source_select;
    logic bank2_source_select;
    logic [6:0] bank2_divide_value;
  } pcr_cfg_t;

  // Blank power-up image; serial writes never persist past reset
  localparam pcr_cfg_t PCR_CFG_POWERUP = '0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_REG = 4'b0011,
    ST_REG_ACK = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RDATA_ACK = 4'b1000
  } pcr_state_t;

endpackage

`default_nettype wire

/* File: testbench/pcr_host_model.sv */
/*
  Bus host model: drives SCL and pulls SDA low, reports every ack bit
  and every read byte as one pulse on res_valid.
  Assumes a pulled-up SDA wire resolved by the bench.
*/
`default_nettype none

module pcr_host_model (
  input wire logic mclk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_pull,
  output logic res_valid,
  output logic [7:0] res_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // SCL half period in MCLK cycles, raised by the bench for a slow host
  int half = 8;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    res_valid = 1'b0;
    res_data = 8'h00;
  end

  // ==========================================================================
  // Bus phases
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One SCL clock, SDA set mid low phase and sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    wt(half / 2);
    sda_pull <= ~b;
    wt(half / 2);
    scl <= 1'b1;
    wt(half / 2);
    s = sda_in;
    wt(half / 2);
    scl <= 1'b0;
  endtask

  task automatic report(input logic [7:0] v);
    res_data <= v;
    res_valid <= 1'b1;
    wt(1);
    res_valid <= 1'b0;
  endtask

  // Start or repeated start, SDA falls while SCL high
  task automatic start();
    sda_pull <= 1'b0;
    wt(half / 2);
    scl <= 1'b1;
    wt(half / 2);
    sda_pull <= 1'b1;
    wt(half / 2);
    scl <= 1'b0;
  endtask

  task automatic stop();
    sda_pull <= 1'b1;
    wt(half / 2);
    scl <= 1'b1;
    wt(half / 2);
    sda_pull <= 1'b0;
    wt(half);
  endtask

  // Whole bytes only, MSB first, ack bit reported as 1
  task automatic byte_wr(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    report({7'h00, ~s});
  endtask

  task automatic byte_rd(input logic nack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
    report(d);
  endtask
endmodule

`default_nettype wire

/* File: testbench/testbench.sv */
/*
  Self-checking bench of the register bank: host model on the bus,
  expected acks and read bytes queued, CFG compared to a register image.
  Assumes the bank answers at 7'h69 and settles CFG within a stop.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pcr_pkg::*;

  logic mclk, reset, scl, sda_pull, sda_out, sda_oe_n, sda_wire, res_valid, s;
  logic [7:0] res_data, e, foreign_addr;
  pcr_cfg_t cfg;
  logic [7:0] rb [256];
  logic [7:0] wd [8];
  logic [7:0] exp_q [$];
  string nm_q [$], n;
  int bad_count, num_checks;

  // ==========================================================================
  // Clock, wire and instances
  always #20 mclk = ~mclk;
  assign sda_wire = ~sda_pull & (sda_oe_n | sda_out);

  pcr_config_regs u_dut (.MCLK(mclk), .RESET(reset), .SERIAL_CLOCK_PIN(scl), .SERIAL_DATA_PIN_IN(sda_wire),
    .SERIAL_DATA_PIN_OUT(sda_out), .SERIAL_DATA_PIN_OE_N(sda_oe_n), .CFG(cfg));
  pcr_host_model u_host (.mclk(mclk), .sda_in(sda_wire), .scl(scl), .sda_pull(sda_pull),
    .res_valid(res_valid), .res_data(res_data));

  // ==========================================================================
  // Expected image
  function automatic logic [7:0] fix(input logic [7:0] a, input logic [7:0] v);
    case (a)
      8'h09: fix = {2'b00, v[5:0]};
      8'h12: fix = {3'b001, v[4:3], 3'b000};
      8'h40: fix = {3'b110, v[4:0]};
      8'h46: fix = {v[7:6], 6'h3f};
      8'h0c, 8'h13, 8'h41, 8'h42, 8'h44, 8'h45, 8'h47: fix = v;
      default: fix = 8'h00;
    endcase
  endfunction

  function automatic pcr_cfg_t exp_cfg();
    exp_cfg = {rb[8'h09][5:0], rb[8'h0c], rb[8'h12][4:3], rb[8'h13], rb[8'h40][4:0], rb[8'h41],
      rb[8'h42], rb[8'h44], rb[8'h45], rb[8'h46][7:6], rb[8'h47]};
  endfunction

  // ==========================================================================
  // Bus tasks and checks
  task automatic expect_res(input logic [7:0] v, input string nm);
    exp_q.push_back(v);
    nm_q.push_back(nm);
  endtask

  task automatic wr(input logic [7:0] a, input int cnt);
    for (int i = 0; i < cnt + 2; i++) expect_res(8'h01, "ack");
    u_host.start();
    u_host.byte_wr(8'hd2);
    u_host.byte_wr(a);
    for (int i = 0; i < cnt; i++) begin
      u_host.byte_wr(wd[i]);
      rb[a + 8'(i)] = fix(a + 8'(i), wd[i]);
    end
    u_host.stop();
  endtask

  task automatic rd(input logic [7:0] a, input int cnt);
    for (int i = 0; i < 3; i++) expect_res(8'h01, "ack");
    for (int i = 0; i < cnt; i++) expect_res(rb[a + 8'(i)], "readback");
    u_host.start();
    u_host.byte_wr(8'hd2);
    u_host.byte_wr(a);
    u_host.start();
    u_host.byte_wr(8'hd3);
    for (int i = 0; i < cnt; i++) u_host.byte_rd(i == cnt - 1);
    u_host.stop();
  endtask

  task automatic chk_cfg();
    num_checks++;
    if (cfg !== exp_cfg() || sda_oe_n !== 1'b1) begin
      bad_count++;
      $display("[FAIL] cfg exp %h got %h oe_n %b", exp_cfg(), cfg, sda_oe_n);
    end
  endtask

  task automatic fill();
    for (int i = 0; i < 8; i++) wd[i] = 8'($urandom());
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Oldest note off the queue whenever the host reports a result
  always @(posedge mclk) begin
    if (res_valid === 1'b1) begin
      num_checks++;
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[FAIL] result exp none got %h", res_data);
      end else begin
        e = exp_q.pop_front();
        n = nm_q.pop_front();
        if (res_data !== e) begin
          bad_count++;
          $display("[FAIL] %s exp %h got %h", n, e, res_data);
        end
      end
    end
  end

  // Watchdog against a hung bus
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    $display("[FAIL] watchdog exp done got hang");
    tally_and_finish();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    bad_count = 0;
    num_checks = 0;
    void'($urandom(32'h1e8b6c51));
    for (int i = 0; i < 256; i++) rb[i] = fix(i[7:0], 8'h00);
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_cfg();
    rd(8'h09, 11);
    $display("reset image test done");
    fill();
    wd[0] = {3'b110, wd[0][4:0]};
    wr(8'h40, 3);
    fill();
    wd[2][5:0] = 6'h3f;
    wr(8'h44, 4);
    fill();
    wd[0][7:6] = 2'b00;
    wr(8'h09, 1);
    fill();
    wr(8'h0c, 1);
    fill();
    wr(8'h13, 1);
    chk_cfg();
    rd(8'h40, 8);
    $display("random fill test done");
    for (int g = 0; g < 4; g++) begin
      wd[0] = {3'b001, 2'(g), 3'b000};
      wr(8'h12, 1);
      chk_cfg();
    end
    $display("gain code test done");
    expect_res(8'h00, "nack");
    // Random foreign address, never equal to the bank's own
    foreign_addr = {PCR_DEV_ADDR ^ 7'($urandom_range(126, 1)), 1'b0};
    u_host.start();
    u_host.byte_wr(foreign_addr);
    u_host.stop();
    fill();
    wr(8'h20, 1);
    rd(8'h20, 1);
    chk_cfg();
    $display("refusal test done");
    expect_res(8'h01, "ack");
    expect_res(8'h01, "ack");
    u_host.start();
    u_host.byte_wr(8'hd2);
    u_host.byte_wr(8'h13);
    for (int i = 0; i < 4; i++) u_host.bit_io(1'b0, s);
    u_host.stop();
    chk_cfg();
    u_host.half = 16;
    fill();
    wr(8'h13, 1);
    rd(8'h13, 1);
    chk_cfg();
    u_host.half = 8;
    $display("abort and slow host test done");
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 256; i++) rb[i] = fix(i[7:0], 8'h00);
    chk_cfg();
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(8'h09, 11);
    wd[0] = 8'h00;
    wr(8'h13, 1);
    chk_cfg();
    $display("second reset test done");
    repeat (10) @(posedge mclk);
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("[FAIL] results exp %0d more got none", exp_q.size());
    end
    tally_and_finish();
  end
endmodule

`default_nettype wire
